// >>> design/mafs_alarm_status.sv
// Purpose: read-only alarm status register of the analog monitor
// Assumes: conversion results, thresholds and enables come from logic on clk
// Notes:   read data is registered, so it appears one cycle after rd_en
`default_nettype none

module mafs_alarm_status
  import mafs_pkg::*;
(
  input  wire logic                    clk,
  input  wire logic                    rst_n,
  input  wire logic                    rd_en,
  input  wire logic [6:0]              rd_addr,
  input  wire mafs_adc_s               adc_evt,
  input  wire mafs_window_s [3:0]      adc_win,
  input  wire mafs_temp_s              local_evt,
  input  wire mafs_temp_s              remote1_evt,
  input  wire mafs_temp_s              remote2_evt,
  input  wire mafs_temp_window_s       local_win,
  input  wire mafs_temp_window_s       remote1_win,
  input  wire mafs_temp_window_s       remote2_win,
  input  wire logic                    local_sensor_enable,
  input  wire logic                    remote1_sensor_enable,
  input  wire logic                    remote2_sensor_enable,
  input  wire logic                    flag_hold_disable,
  output var  logic [15:0]             rd_data_ff,
  output var  logic                    rd_valid_ff,
  output wire logic [15:0]             alarm_status
);

  // ---------------------------------------------------------------
  // conversion window checks
  // ---------------------------------------------------------------
  mafs_window_s      adc_sel_win;
  logic              adc_above_u;
  logic              adc_below_u;
  logic              adc_above_s;
  logic              adc_below_s;
  logic              adc_out;

  assign adc_sel_win = adc_win[adc_evt.chan];
  assign adc_above_u = adc_evt.result > adc_sel_win.hi;
  assign adc_below_u = adc_evt.result < adc_sel_win.lo;
  // differential results are two's complement, single-ended are straight binary
  assign adc_above_s = $signed(adc_evt.result) > $signed(adc_sel_win.hi);
  assign adc_below_s = $signed(adc_evt.result) < $signed(adc_sel_win.lo);
  assign adc_out     = adc_evt.diff ? (adc_above_s | adc_below_s) : (adc_above_u | adc_below_u);

  // the pair results land on the even input of each pair
  logic upd_in0;
  logic upd_in1;
  logic upd_in2;
  logic upd_in3;

  assign upd_in0 = adc_evt.done & (adc_evt.chan == 2'h0);
  assign upd_in1 = adc_evt.done & (adc_evt.chan == 2'h1) & ~adc_evt.diff;
  assign upd_in2 = adc_evt.done & (adc_evt.chan == 2'h2);
  assign upd_in3 = adc_evt.done & (adc_evt.chan == 2'h3) & ~adc_evt.diff;

  // ---------------------------------------------------------------
  // temperature window checks
  // ---------------------------------------------------------------
  logic local_under;
  logic local_over;
  logic remote1_under;
  logic remote1_over;
  logic remote2_under;
  logic remote2_over;

  assign local_under   = $signed(local_evt.temp) < $signed(local_win.lo);
  assign local_over    = $signed(local_evt.temp) > $signed(local_win.hi);
  assign remote1_under = $signed(remote1_evt.temp) < $signed(remote1_win.lo);
  assign remote1_over  = $signed(remote1_evt.temp) > $signed(remote1_win.hi);
  assign remote2_under = $signed(remote2_evt.temp) < $signed(remote2_win.lo);
  assign remote2_over  = $signed(remote2_evt.temp) > $signed(remote2_win.hi);

  // ---------------------------------------------------------------
  // die over-temperature with hysteresis
  // ---------------------------------------------------------------
  logic die_hot_ff;
  logic nxt_die_hot;
  logic die_at_trip;
  logic die_released;

  assign die_at_trip  = $signed(local_evt.temp) >= DIE_TRIP_CODE;
  assign die_released = $signed(local_evt.temp) <= DIE_RELEASE_CODE;
  // between release and trip the previous state is kept
  assign nxt_die_hot  = ~local_sensor_enable ? 1'b0 :
                        ~local_evt.done      ? die_hot_ff :
                        die_at_trip          ? 1'b1 :
                        die_released         ? 1'b0 : die_hot_ff;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      die_hot_ff <= 1'b0;
    end else begin
      die_hot_ff <= nxt_die_hot;
    end
  end

  // ---------------------------------------------------------------
  // per-flag strobes, conditions and enables
  // ---------------------------------------------------------------
  logic [FLAG_MSB:FLAG_LSB] flag_upd;
  logic [FLAG_MSB:FLAG_LSB] flag_cond;
  logic [FLAG_MSB:FLAG_LSB] flag_gate;
  logic [FLAG_MSB:FLAG_LSB] flag_q;

  // masking of the alarm pin is done elsewhere, so the flags never see it
  assign flag_upd = {upd_in0, upd_in1, upd_in2, upd_in3,
                     local_evt.done, local_evt.done,
                     remote1_evt.done, remote1_evt.done,
                     remote2_evt.done, remote2_evt.done,
                     remote1_evt.done, remote2_evt.done,
                     local_evt.done};

  assign flag_cond = {adc_out, adc_out, adc_out, adc_out,
                      local_under, local_over,
                      remote1_under, remote1_over,
                      remote2_under, remote2_over,
                      remote1_evt.fault, remote2_evt.fault,
                      nxt_die_hot};

  assign flag_gate = {4'hF,
                      local_sensor_enable, local_sensor_enable,
                      remote1_sensor_enable, remote1_sensor_enable,
                      remote2_sensor_enable, remote2_sensor_enable,
                      remote1_sensor_enable, remote2_sensor_enable,
                      local_sensor_enable};

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  logic rd_hit;

  assign rd_hit = rd_en & (rd_addr == ALARM_STATUS_ADDR);

  generate
    for (genvar i = FLAG_LSB; i <= FLAG_MSB; i++) begin : g_flag
      mafs_flag_cell u_cell (
        .clk      (clk),
        .rst_n    (rst_n),
        .gate     (flag_gate[i]),
        .upd      (flag_upd[i]),
        .cond     (flag_cond[i]),
        .hold_dis (flag_hold_disable),
        .rd_clr   (rd_hit),
        .flag_ff  (flag_q[i])
      );
    end
  endgenerate

  // reserved bits are constant zero
  assign alarm_status = {1'b0, flag_q, 2'b00};

  // other addresses belong to other register blocks, which is why a miss returns zero
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data_ff  <= ALARM_STATUS_RESET;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff  <= rd_hit ? alarm_status : READ_IDLE_DATA;
      rd_valid_ff <= rd_en;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_in0_set;
    upd_in0 && adc_out |=> alarm_status[BIT_INPUT0_RANGE];
  endproperty
  a_in0_set: assert property (p_in0_set) else $error("input 0 flag not set");

  property p_in1_clear;
    flag_hold_disable && upd_in1 && !adc_out && !rd_hit ##1 flag_hold_disable
      |-> !alarm_status[BIT_INPUT1_RANGE];
  endproperty
  a_in1_clear: assert property (p_in1_clear) else $error("input 1 flag set in range");

  property p_in2_pair;
    adc_evt.done && adc_evt.diff && adc_evt.chan == 2'h2 && (adc_above_s || adc_below_s)
      |=> alarm_status[BIT_INPUT2_RANGE];
  endproperty
  a_in2_pair: assert property (p_in2_pair) else $error("pair 2/3 flag not set");

  property p_in3_set;
    upd_in3 && adc_out |=> alarm_status[BIT_INPUT3_RANGE] && !alarm_status[15];
  endproperty
  a_in3_set: assert property (p_in3_set) else $error("input 3 flag not set");

  property p_local_under;
    local_evt.done && local_sensor_enable && local_under ##1 local_sensor_enable
      |-> alarm_status[BIT_LOCAL_UNDER];
  endproperty
  a_local_under: assert property (p_local_under) else $error("local under flag missing");

  property p_local_over;
    local_evt.done && local_sensor_enable && local_over ##1 local_sensor_enable
      |-> alarm_status[BIT_LOCAL_OVER];
  endproperty
  a_local_over: assert property (p_local_over) else $error("local over flag missing");

  property p_remote1_temp;
    remote1_evt.done && remote1_sensor_enable && remote1_under && remote1_over == 1'b0 ##1 remote1_sensor_enable
      |-> alarm_status[BIT_REMOTE1_UNDER];
  endproperty
  a_remote1_temp: assert property (p_remote1_temp) else $error("remote 1 under flag missing");

  property p_remote1_over;
    remote1_evt.done && remote1_sensor_enable && remote1_over ##1 remote1_sensor_enable
      |-> alarm_status[BIT_REMOTE1_OVER];
  endproperty
  a_remote1_over: assert property (p_remote1_over) else $error("remote 1 over flag missing");

  property p_remote2_under;
    remote2_evt.done && remote2_sensor_enable && remote2_under ##1 remote2_sensor_enable
      |-> alarm_status[BIT_REMOTE2_UNDER];
  endproperty
  a_remote2_under: assert property (p_remote2_under) else $error("remote 2 under flag missing");

  property p_remote2_over;
    remote2_evt.done && remote2_sensor_enable && remote2_over ##1 remote2_sensor_enable
      |-> alarm_status[BIT_REMOTE2_OVER];
  endproperty
  a_remote2_over: assert property (p_remote2_over) else $error("remote 2 over flag missing");

  property p_remote_fault;
    remote1_evt.done && remote1_sensor_enable && remote1_evt.fault ##1 remote1_sensor_enable
      |-> alarm_status[BIT_REMOTE1_FAULT];
  endproperty
  a_remote_fault: assert property (p_remote_fault) else $error("remote 1 fault flag missing");

  property p_remote2_fault;
    flag_hold_disable && remote2_evt.done && !remote2_evt.fault ##1 flag_hold_disable
      |-> !alarm_status[BIT_REMOTE2_FAULT];
  endproperty
  a_remote2_fault: assert property (p_remote2_fault) else $error("remote 2 fault flag stuck");

  property p_local_off;
    !local_sensor_enable |=> !alarm_status[BIT_LOCAL_UNDER] && !alarm_status[BIT_LOCAL_OVER];
  endproperty
  a_local_off: assert property (p_local_off) else $error("local flags set while disabled");

  property p_remote_off;
    !remote1_sensor_enable |=> (alarm_status[8:7] == 2'b00) && !alarm_status[BIT_REMOTE1_FAULT];
  endproperty
  a_remote_off: assert property (p_remote_off) else $error("remote 1 flags set while disabled");

  property p_die_trip;
    local_evt.done && local_sensor_enable && die_at_trip ##1 local_sensor_enable
      |-> alarm_status[BIT_DIE_OVERHEAT];
  endproperty
  a_die_trip: assert property (p_die_trip) else $error("die flag not set at trip");

  property p_die_hyst;
    die_hot_ff && local_sensor_enable && local_evt.done && !die_released |=> die_hot_ff;
  endproperty
  a_die_hyst: assert property (p_die_hyst) else $error("die condition ended inside hysteresis");

  property p_die_off;
    !local_sensor_enable |=> !alarm_status[BIT_DIE_OVERHEAT] && !die_hot_ff;
  endproperty
  a_die_off: assert property (p_die_off) else $error("die flag set while sensor off");

  property p_reserved;
    rd_valid_ff |-> rd_data_ff[15] == 1'b0 && rd_data_ff[1:0] == 2'b00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits read nonzero");

  property p_read_data;
    rd_hit |=> rd_valid_ff && rd_data_ff == $past(alarm_status);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data mismatch");

  property p_hold;
    !flag_hold_disable && alarm_status[BIT_INPUT0_RANGE] && !rd_hit ##1 !flag_hold_disable
      |-> alarm_status[BIT_INPUT0_RANGE];
  endproperty
  a_hold: assert property (p_hold) else $error("held flag dropped without read");

  property p_no_hold;
    flag_hold_disable && upd_in0 && !adc_out ##1 flag_hold_disable
      |-> !alarm_status[BIT_INPUT0_RANGE];
  endproperty
  a_no_hold: assert property (p_no_hold) else $error("flag stayed with holding off");

  property p_quiet;
    !adc_evt.done && !rd_hit && $stable(flag_hold_disable) |=> $stable(alarm_status[14:11]);
  endproperty
  a_quiet: assert property (p_quiet) else $error("input flag changed without event");

  c_in0_set:   cover property (upd_in0 && adc_out ##1 alarm_status[BIT_INPUT0_RANGE]);
  c_die_trip:  cover property (local_evt.done && die_at_trip ##1 alarm_status[BIT_DIE_OVERHEAT]);
  c_read_clr:  cover property (alarm_status[BIT_INPUT0_RANGE] && rd_hit ##1 !alarm_status[BIT_INPUT0_RANGE]);
  c_no_hold:   cover property (flag_hold_disable && alarm_status[BIT_INPUT1_RANGE] ##1 !alarm_status[13]);

endmodule : mafs_alarm_status

`default_nettype wire

// >>> design/mafs_flag_cell.sv
// Purpose: one alarm flag with optional hold-until-read behaviour
// Assumes: upd is a one-cycle strobe carrying a fresh comparison in cond
// Notes:   a new set beats a read clear in the same cycle
`default_nettype none

module mafs_flag_cell
  import mafs_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic gate,
  input  wire logic upd,
  input  wire logic cond,
  input  wire logic hold_dis,
  input  wire logic rd_clr,
  output var  logic flag_ff
);

  logic cond_ff;
  logic nxt_cond;
  logic nxt_flag;
  logic clr_ok;

  // a disabled sensor forces both the condition and the flag low
  assign nxt_cond = gate & (upd ? cond : cond_ff);
  // clear only if the condition had already gone when the host read
  assign clr_ok   = rd_clr & ~cond_ff;
  assign nxt_flag = ~gate    ? 1'b0 :
                    hold_dis ? nxt_cond :
                    (nxt_cond | (flag_ff & ~clr_ok));

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cond_ff <= 1'b0;
      flag_ff <= 1'b0;
    end else begin
      cond_ff <= nxt_cond;
      flag_ff <= nxt_flag;
    end
  end

endmodule : mafs_flag_cell

`default_nettype wire

// >>> design/mafs_pkg.sv
// Purpose: shared constants and carriers of the alarm status flag bank
// Assumes: 12-bit conversion codes, 12-bit two's complement temperatures
// Notes:   temperature scale is a plain default, change with the sensor
`default_nettype none

package mafs_pkg;

  // register map
  localparam logic [6:0]  ALARM_STATUS_ADDR  = 7'h4F;
  localparam logic [15:0] ALARM_STATUS_RESET = 16'h0000;
  localparam logic [15:0] READ_IDLE_DATA     = 16'h0000;

  // field positions inside alarm_status
  localparam int BIT_INPUT0_RANGE  = 14;
  localparam int BIT_INPUT1_RANGE  = 13;
  localparam int BIT_INPUT2_RANGE  = 12;
  localparam int BIT_INPUT3_RANGE  = 11;
  localparam int BIT_LOCAL_UNDER   = 10;
  localparam int BIT_LOCAL_OVER    = 9;
  localparam int BIT_REMOTE1_UNDER = 8;
  localparam int BIT_REMOTE1_OVER  = 7;
  localparam int BIT_REMOTE2_UNDER = 6;
  localparam int BIT_REMOTE2_OVER  = 5;
  localparam int BIT_REMOTE1_FAULT = 4;
  localparam int BIT_REMOTE2_FAULT = 3;
  localparam int BIT_DIE_OVERHEAT  = 2;
  localparam int FLAG_LSB          = 2;
  localparam int FLAG_MSB          = 14;

  // widths
  localparam int ADC_W  = 12;
  localparam int TEMP_W = 12;

  // die over-temperature trip, in degrees and in codes
  localparam int DIE_TRIP_C     = 150;
  localparam int DIE_HYST_C     = 8;
  localparam int TEMP_LSB_PER_C = 8;
  localparam logic signed [TEMP_W-1:0] DIE_TRIP_CODE    = TEMP_W'(DIE_TRIP_C * TEMP_LSB_PER_C);
  localparam logic signed [TEMP_W-1:0] DIE_RELEASE_CODE = TEMP_W'((DIE_TRIP_C - DIE_HYST_C) * TEMP_LSB_PER_C);

  typedef struct packed {
    logic [ADC_W-1:0] hi;
    logic [ADC_W-1:0] lo;
  } mafs_window_s;

  typedef struct packed {
    logic             done;
    logic [1:0]       chan;
    logic             diff;
    logic [ADC_W-1:0] result;
  } mafs_adc_s;

  typedef struct packed {
    logic              done;
    logic              fault;
    logic [TEMP_W-1:0] temp;
  } mafs_temp_s;

  typedef struct packed {
    logic [TEMP_W-1:0] hi;
    logic [TEMP_W-1:0] lo;
  } mafs_temp_window_s;

endpackage : mafs_pkg

`default_nettype wire

// >>> test/mafs_alarm_status_tb.sv
// Purpose: self-checking bench of the alarm status flag bank
// Assumes: 200 MHz clock, synchronous active-low reset, host model reads
// Notes:   flags are judged through reads and the live vector; each check leaves a note in a queue
`default_nettype none

module mafs_alarm_status_tb
  import mafs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic              clk;
  logic              rst_n;
  logic              rd_en;
  logic              rd_valid_ff;
  logic              hold_dis;
  logic [6:0]        rd_addr;
  logic [15:0]       rd_data_ff;
  logic [15:0]       alarm_status;
  logic [2:0]        en;
  mafs_adc_s         adc_evt;
  mafs_window_s [3:0] adc_win;
  mafs_temp_s        loc_e;
  mafs_temp_s        r1_e;
  mafs_temp_s        r2_e;
  mafs_temp_window_s tw;
  logic [15:0]       notes[$];
  logic [15:0]       live_notes[$];
  logic              live_req;
  int                n_errors;
  int                samples_checked;

  mafs_alarm_status u_dut (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .rd_en                 (rd_en),
    .rd_addr               (rd_addr),
    .adc_evt               (adc_evt),
    .adc_win               (adc_win),
    .local_evt             (loc_e),
    .remote1_evt           (r1_e),
    .remote2_evt           (r2_e),
    .local_win             (tw),
    .remote1_win           (tw),
    .remote2_win           (tw),
    .local_sensor_enable   (en[0]),
    .remote1_sensor_enable (en[1]),
    .remote2_sensor_enable (en[2]),
    .flag_hold_disable     (hold_dis),
    .rd_data_ff            (rd_data_ff),
    .rd_valid_ff           (rd_valid_ff),
    .alarm_status          (alarm_status)
  );

  mafs_host_model u_host (
    .clk     (clk),
    .rd_en   (rd_en),
    .rd_addr (rd_addr)
  );

  always #2.5 clk = ~clk;

  task automatic cmp16(input logic [15:0] e, input logic [15:0] a);
    samples_checked++;
    if (a !== e) begin
      n_errors++;
      $display("Error t=%0t exp=%h got=%h", $time, e, a);
    end
  endtask : cmp16

  task automatic cmp_live(input logic [15:0] e, input logic [15:0] a);
    samples_checked++;
    if (a !== e) begin
      n_errors++;
      $display("Error t=%0t live exp=%h got=%h", $time, e, a);
    end
  endtask : cmp_live

  task automatic results();
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : results

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    notes.push_back(e);
    u_host.rd(a);
  endtask : rdchk

  // non-blocking, so the watcher sees the request only at the next falling edge
  task automatic livechk(input logic [15:0] e);
    live_notes.push_back(e);
    @(negedge clk);
    live_req <= 1'b1;
    @(negedge clk);
    live_req <= 1'b0;
  endtask : livechk

  // two idle cycles after the strobe so the flag has surely landed
  task automatic adc(input logic [1:0] c, input logic d, input logic [11:0] r);
    @(negedge clk);
    adc_evt = '{1'b1, c, d, r};
    @(negedge clk);
    adc_evt.done = 1'b0;
    repeat (2) @(negedge clk);
  endtask : adc

  task automatic tmp(input int s, input logic f, input logic [11:0] t);
    @(negedge clk);
    case (s)
      0: loc_e = '{1'b1, f, t};
      1: r1_e = '{1'b1, f, t};
      default: r2_e = '{1'b1, f, t};
    endcase
    @(negedge clk);
    loc_e.done = 1'b0;
    r1_e.done  = 1'b0;
    r2_e.done  = 1'b0;
    repeat (2) @(negedge clk);
  endtask : tmp

  always @(negedge clk) begin
    if (rd_valid_ff === 1'b1) begin
      if (notes.size() != 0) cmp16(notes.pop_front(), rd_data_ff);
      else begin
        n_errors++;
        $display("Error t=%0t exp=none got=%h", $time, rd_data_ff);
      end
    end
    if (live_req === 1'b1) begin
      if (live_notes.size() != 0) cmp_live(live_notes.pop_front(), alarm_status);
      else begin
        n_errors++;
        $display("Error t=%0t live exp=none got=%h", $time, alarm_status);
      end
    end
  end

  initial begin
    clk      = 1'b0;
    rst_n    = 1'b0;
    hold_dis = 1'b1;
    en       = 3'b111;
    adc_evt  = '0;
    loc_e    = '0;
    r1_e     = '0;
    r2_e     = '0;
    adc_win  = {4{24'h0C8064}};
    tw       = {12'h190, 12'hFB0};
    n_errors = 0;
    samples_checked = 0;
    live_req = 1'b0;
    void'($urandom(32'h43cff609));
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rdchk(7'h4F, 16'h0000);
    rdchk(7'h00, 16'h0000);
    for (int c = 0; c < 4; c++) begin
      adc(c[1:0], 1'b0, 12'(201 + $urandom % 3000));
      livechk(16'h4000 >> c);
      rdchk(7'h4F, 16'h4000 >> c);
      adc(c[1:0], 1'b0, 12'($urandom % 100));
      rdchk(7'h4F, 16'h4000 >> c);
      adc(c[1:0], 1'b0, 12'(100 + $urandom % 101));
      rdchk(7'h4F, 16'h0000);
    end
    // signed window: an unsigned compare would flag the small negative code
    adc_win[0] = {12'h064, 12'hF9C};
    adc_win[2] = {12'h064, 12'hF9C};
    adc(2'd0, 1'b1, 12'hFF0);
    rdchk(7'h4F, 16'h0000);
    adc(2'd0, 1'b1, 12'hF00);
    rdchk(7'h4F, 16'h4000);
    adc(2'd1, 1'b1, 12'hF00);
    rdchk(7'h4F, 16'h4000);
    adc(2'd2, 1'b1, 12'h7FF);
    rdchk(7'h4F, 16'h5000);
    adc(2'd0, 1'b1, 12'h000);
    adc(2'd2, 1'b1, 12'h000);
    rdchk(7'h4F, 16'h0000);
    for (int s = 0; s < 3; s++) begin
      tmp(s, 1'b0, 12'hF00);
      rdchk(7'h4F, 16'h0400 >> (2 * s));
      tmp(s, 1'b0, 12'h200);
      rdchk(7'h4F, 16'h0200 >> (2 * s));
      tmp(s, 1'b0, 12'h000);
      rdchk(7'h4F, 16'h0000);
    end
    tmp(1, 1'b1, 12'h000);
    rdchk(7'h4F, 16'h0010);
    tmp(2, 1'b1, 12'h000);
    rdchk(7'h4F, 16'h0018);
    tmp(1, 1'b0, 12'h000);
    tmp(2, 1'b0, 12'h000);
    rdchk(7'h4F, 16'h0000);
    en = 3'b000;
    for (int s = 0; s < 3; s++) tmp(s, 1'b1, 12'hF00);
    rdchk(7'h4F, 16'h0000);
    en = 3'b111;
    tmp(0, 1'b0, 12'h4B0);
    rdchk(7'h4F, 16'h0204);
    tmp(0, 1'b0, 12'h471);
    rdchk(7'h4F, 16'h0204);
    tmp(0, 1'b0, 12'h470);
    rdchk(7'h4F, 16'h0200);
    tmp(0, 1'b0, 12'h4AF);
    rdchk(7'h4F, 16'h0200);
    tmp(0, 1'b0, 12'h4B0);
    en[0] = 1'b0;
    repeat (2) @(negedge clk);
    rdchk(7'h4F, 16'h0000);
    en[0] = 1'b1;
    // held mode: a read only clears once the condition has gone
    hold_dis = 1'b0;
    tmp(2, 1'b0, 12'h200);
    adc(2'd0, 1'b1, 12'hF00);
    rdchk(7'h4F, 16'h4020);
    rdchk(7'h4F, 16'h4020);
    tmp(2, 1'b0, 12'h000);
    adc(2'd0, 1'b1, 12'h000);
    livechk(16'h4020);
    rdchk(7'h4E, 16'h0000);
    rdchk(7'h4F, 16'h4020);
    livechk(16'h0000);
    rdchk(7'h4F, 16'h0000);
    tmp(1, 1'b0, 12'hF00);
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    rdchk(7'h4F, 16'h0000);
    for (int i = 0; i < 20 && (notes.size() + live_notes.size()) != 0; i++) @(negedge clk);
    if ((notes.size() + live_notes.size()) != 0) n_errors++;
    results();
  end

endmodule : mafs_alarm_status_tb

`default_nettype wire

// >>> test/mafs_host_model.sv
// Purpose: host side model that issues status register reads
// Assumes: inputs change on the falling edge of clk
// Notes:   one-cycle read strobe; the address is scrambled once released
`default_nettype none

module mafs_host_model (
  input  wire logic       clk,
  output var  logic       rd_en,
  output var  logic [6:0] rd_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    rd_en   = 1'b0;
    rd_addr = 7'h00;
  end

  // inverted address after release so a stale value never looks like a hit
  task automatic rd(input logic [6:0] a);
    @(negedge clk);
    rd_en   = 1'b1;
    rd_addr = a;
    @(negedge clk);
    rd_en   = 1'b0;
    rd_addr = ~a;
  endtask : rd

endmodule : mafs_host_model

`default_nettype wire
